// ### logic/blg_pkg.sv
// Shared constants for the LED charge gauge: timing, register map,
// field positions, reset values and the segment threshold tables.
// Assumes a single 20 MHz system clock feeding the whole block.
package blg_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ        = 20_000_000;
	localparam int DISPLAY_REQUEST_INPUT_TIME_MS  = 4000;
	localparam int BLINK_HALF_MS = 250;
	localparam int DISPLAY_REQUEST_INPUT_CYC      = DISPLAY_REQUEST_INPUT_TIME_MS * (CLK_HZ / 1000);
	localparam int BLINK_CYC     = BLINK_HALF_MS * (CLK_HZ / 1000);
	localparam int TMR_W         = 27;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int          ADDR_W     = 4;
	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_STATUS = 4'h4;
	localparam logic [3:0]  REG_ALARM  = 4'h8;

	// Control fields
	localparam int          CTRL_MODE_BIT = 0;
	localparam int          CTRL_SEG_LSB  = 1;
	localparam logic [2:0]  CTRL_RST      = 3'h4;
	localparam logic [15:0] ALARM_RST     = 16'h0000;

	// Status fields
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_BLINK_BIT  = 1;
	localparam int ST_EOD_BIT    = 2;
	localparam int ST_SEG_LSB    = 8;

	// ****************************************
	// Segment selection and thresholds
	// ****************************************
	typedef enum logic [1:0] {
		BLG_SEG3 = 2'h0,
		BLG_SEG4 = 2'h1,
		BLG_SEG5 = 2'h2
	} blg_segsel_e;

	localparam int          MAX_SEG   = 5;
	localparam int          CAP_W     = 16;
	localparam int          PROD_W    = 24;
	localparam logic [6:0]  PCT_SCALE = 7'h64;
	// Boundaries packed low to high, seven bits each
	localparam logic [27:0] THR5 = {7'h50, 7'h3c, 7'h28, 7'h14};
	localparam logic [27:0] THR4 = {7'h00, 7'h4b, 7'h32, 7'h19};
	localparam logic [27:0] THR3 = {7'h00, 7'h00, 7'h43, 7'h22};

endpackage

// ### logic/blg_seg_decode.sv
// Turns a charge figure and a full-scale reference into a bar of lit segments.
// Assumes inputs are stable on the system clock; output is combinational.
`timescale 1ns/1ps
`default_nettype none
module blg_seg_decode
	import blg_pkg::*;
(
	input  wire logic [blg_pkg::CAP_W-1:0]   charge,
	input  wire logic [blg_pkg::CAP_W-1:0]   reference,
	input  wire logic [1:0]                  seg_sel,
	output logic      [blg_pkg::MAX_SEG-1:0] lit
);

	// ****************************************
	// Threshold selection
	// ****************************************
	logic [27:0]       thr_tab;
	logic [2:0]        n_bound;
	logic [PROD_W-1:0] lhs;

	// Charge scaled to percent; avoids a divider
	assign lhs = PROD_W'(charge) * PROD_W'(PCT_SCALE);

	// Table per segment count; unused code falls back to five
	always_comb begin
		case (seg_sel)
			BLG_SEG3: begin
				thr_tab = THR3;
				n_bound = 3'h2;
			end
			BLG_SEG4: begin
				thr_tab = THR4;
				n_bound = 3'h3;
			end
			default: begin
				thr_tab = THR5;
				n_bound = 3'h4;
			end
		endcase
	end

	// First segment always lit; empty still shows one bar
	assign lit[0] = 1'b1;

	// ****************************************
	// One comparator per boundary
	// ****************************************
	for (genvar i = 0; i < MAX_SEG - 1; i++) begin : g_bound
		logic [PROD_W-1:0] rhs;
		assign rhs = PROD_W'(reference) * PROD_W'(thr_tab[i*7 +: 7]);
		// Each step is a fixed share of the reference
		assign lit[i+1] = (3'(i) < n_bound) && (lhs >= rhs);
	end

endmodule
`default_nettype wire

// ### logic/blg_gauge_display.sv
// LED bar-graph charge display: pushbutton timer, scaling, blinking
// and an Avalon-MM register slave with waitrequest.
// Assumes charge figures and the discharge flag come from logic on ref_clk;
// the pushbutton pin is asynchronous and is synchronised here.
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - A falling edge on the request pin lights the display for 4 s.
// - Re-arming needs high then low again; falls during the window are ignored.
// - Relative uses full-charge capacity as reference, absolute uses design capacity.
// - Mode bit picks the scale; two bits pick three, four or five segments.
// - Each segment is 20, 25 or 33 percent of the reference capacity.
// - Lit segments blink while remaining charge is below the alarm level.
// - With end of discharge set, all dark and requests ignored.
// - Five segments: bounds at 20, 40, 60 and 80 percent.
// - Four segments: bounds at 25, 50 and 75 percent.
// - Three segments: bounds at 34 and 67 percent.
module blg_gauge_display
	import blg_pkg::*;
#(
	parameter int DISPLAY_REQUEST_INPUT_CYCLES  = blg_pkg::DISPLAY_REQUEST_INPUT_CYC,
	parameter int BLINK_CYCLES = blg_pkg::BLINK_CYC
) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        clk_en,
	input  wire logic [blg_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic                        display_request_input,
	input  wire logic                        end_of_discharge_flag,
	input  wire logic [blg_pkg::CAP_W-1:0]   full_charge_capacity,
	input  wire logic [blg_pkg::CAP_W-1:0]   design_capacity,
	input  wire logic [blg_pkg::CAP_W-1:0]   remaining_charge,
	output logic      [blg_pkg::MAX_SEG-1:0] segment_out
);
	import blg_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic {
		BLG_IDLE,
		BLG_SHOW
	} blg_state_e;

	localparam logic [TMR_W-1:0] DISPLAY_REQUEST_INPUT_LOAD  = TMR_W'(DISPLAY_REQUEST_INPUT_CYCLES - 1);
	localparam logic [TMR_W-1:0] BLINK_LOAD = TMR_W'(BLINK_CYCLES - 1);

	blg_state_e            state_r;
	blg_state_e            state_nxt;
	logic [TMR_W-1:0]      tmr_r;
	logic [TMR_W-1:0]      blink_cnt_r;
	logic                  phase_r;
	logic                  req_s1_r;
	logic                  req_s2_r;
	logic                  req_prev_r;
	logic                  fall;
	logic                  accept;
	logic                  alarm;
	logic [2:0]            ctrl_r;
	logic [CAP_W-1:0]      alarm_lvl_r;
	logic [CAP_W-1:0]      ref_cap;
	logic [MAX_SEG-1:0]    lit;
	logic [MAX_SEG-1:0]    seg_nxt;
	logic                  req;
	logic                  bus_ack;
	logic [31:0]           rd_nxt;

	// ****************************************
	// Pushbutton synchroniser and edge detect
	// ****************************************
	// Two flops against metastability, a third only for the edge
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_s1_r   <= 1'b1;
			req_s2_r   <= 1'b1;
			req_prev_r <= 1'b1;
		end else if (clk_en) begin
			req_s1_r   <= display_request_input;
			req_s2_r   <= req_s1_r;
			req_prev_r <= req_s2_r;
		end
	end

	// High then low is required, so a held button never re-fires
	assign fall   = req_prev_r && !req_s2_r;
	// Only taken when idle and not at end of discharge
	assign accept = fall && (state_r == BLG_IDLE) && !end_of_discharge_flag;

	// ****************************************
	// Display window state machine
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			BLG_IDLE: begin
				if (accept) begin
					state_nxt = BLG_SHOW;
				end
			end
			BLG_SHOW: begin
				if (tmr_r == '0) begin
					state_nxt = BLG_IDLE;
				end
			end
			default: begin
				state_nxt = BLG_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= BLG_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
		end
	end

	// Window timer; loaded on activation, never reloaded mid-window
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr_r <= '0;
		end else if (clk_en) begin
			if (accept) begin
				tmr_r <= DISPLAY_REQUEST_INPUT_LOAD;
			end else if (state_r == BLG_SHOW && tmr_r != '0) begin
				tmr_r <= tmr_r - TMR_W'(1);
			end
		end
	end

	// ****************************************
	// Blink timing
	// ****************************************
	// Restarts lit on each activation so the first view is never dark
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_r <= '0;
			phase_r     <= 1'b1;
		end else if (clk_en) begin
			if (accept) begin
				blink_cnt_r <= BLINK_LOAD;
				phase_r     <= 1'b1;
			end else if (blink_cnt_r == '0) begin
				blink_cnt_r <= BLINK_LOAD;
				phase_r     <= !phase_r;
			end else begin
				blink_cnt_r <= blink_cnt_r - TMR_W'(1);
			end
		end
	end

	assign alarm = remaining_charge < alarm_lvl_r;

	// ****************************************
	// Scaling and segment drive
	// ****************************************
	// Reference picked by the scale bit
	assign ref_cap = ctrl_r[CTRL_MODE_BIT] ? design_capacity : full_charge_capacity;

	blg_seg_decode u_decode (
		.charge    (remaining_charge),
		.reference (ref_cap),
		.seg_sel   (ctrl_r[CTRL_SEG_LSB +: 2]),
		.lit       (lit)
	);

	// Dark outside the window, at end of discharge, or in blink-off half
	always_comb begin
		seg_nxt = '0;
		if (state_r == BLG_SHOW && !end_of_discharge_flag) begin
			if (!alarm || phase_r) begin
				seg_nxt = lit;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			segment_out <= '0;
		end else if (clk_en) begin
			segment_out <= seg_nxt;
		end
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	// One wait cycle per access; answer lands on the second edge
	assign req     = avs_read || avs_write;
	assign bus_ack = req && !avs_waitrequest;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else if (clk_en) begin
			avs_waitrequest <= !(req && avs_waitrequest);
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (avs_address)
			REG_CTRL: begin
				rd_nxt[2:0] = ctrl_r;
			end
			REG_STATUS: begin
				rd_nxt[ST_ACTIVE_BIT] = (state_r == BLG_SHOW);
				rd_nxt[ST_BLINK_BIT]  = alarm;
				rd_nxt[ST_EOD_BIT]    = end_of_discharge_flag;
				rd_nxt[ST_SEG_LSB +: MAX_SEG] = segment_out;
			end
			REG_ALARM: begin
				rd_nxt[CAP_W-1:0] = alarm_lvl_r;
			end
			default: begin
				rd_nxt = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= rd_nxt;
			end
		end
	end

	// Writes act only on the edge the master sees waitrequest low
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r      <= CTRL_RST;
			alarm_lvl_r <= ALARM_RST;
		end else if (clk_en) begin
			if (bus_ack && avs_write) begin
				if (avs_address == REG_CTRL && avs_byteenable[0]) begin
					ctrl_r <= avs_writedata[2:0];
				end
				if (avs_address == REG_ALARM) begin
					if (avs_byteenable[0]) begin
						alarm_lvl_r[7:0] <= avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						alarm_lvl_r[15:8] <= avs_writedata[15:8];
					end
				end
			end
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_accept;
		accept ##0 clk_en;
	endsequence

	sequence s_window_open;
		state_r == BLG_SHOW && tmr_r == DISPLAY_REQUEST_INPUT_LOAD;
	endsequence

	property p_fall_opens;
		@(posedge ref_clk) disable iff (!rst_n)
		s_accept |=> s_window_open;
	endproperty
	a_fall_opens: assert property (p_fall_opens) else $error("activation did not open window");

	property p_no_reload;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && state_r == BLG_SHOW && tmr_r != '0) |=> (tmr_r == $past(tmr_r) - TMR_W'(1));
	endproperty
	a_no_reload: assert property (p_no_reload) else $error("timer reloaded inside window");

	property p_held_low;
		@(posedge ref_clk) disable iff (!rst_n)
		(!req_prev_r && !req_s2_r) |-> !accept;
	endproperty
	a_held_low: assert property (p_held_low) else $error("held input re-triggered");

	property p_ref_sel;
		@(posedge ref_clk) disable iff (!rst_n)
		ref_cap == (ctrl_r[CTRL_MODE_BIT] ? design_capacity : full_charge_capacity);
	endproperty
	a_ref_sel: assert property (p_ref_sel) else $error("wrong full-scale reference");

	property p_seg_limit;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && ctrl_r[CTRL_SEG_LSB +: 2] == BLG_SEG3) |=> (segment_out[4:3] == 2'h0);
	endproperty
	a_seg_limit: assert property (p_seg_limit) else $error("segment beyond count lit");

	property p_blink_off;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && state_r == BLG_SHOW && alarm && !phase_r) |=> (segment_out == '0);
	endproperty
	a_blink_off: assert property (p_blink_off) else $error("alarm blink-off not dark");

	property p_eod_dark;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && end_of_discharge_flag) |=> (segment_out == '0);
	endproperty
	a_eod_dark: assert property (p_eod_dark) else $error("segments lit at end of discharge");

	property p_eod_ignore;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && state_r == BLG_IDLE && end_of_discharge_flag) |=> (state_r == BLG_IDLE);
	endproperty
	a_eod_ignore: assert property (p_eod_ignore) else $error("activation taken at end of discharge");

	property p_first_seg;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && state_r == BLG_SHOW && !end_of_discharge_flag && !alarm) |=> segment_out[0];
	endproperty
	a_first_seg: assert property (p_first_seg) else $error("first segment dark in window");

	property p_idle_dark;
		@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && state_r == BLG_SHOW && tmr_r == '0) |=> (state_r == BLG_IDLE) ##1 (segment_out == '0);
	endproperty
	a_idle_dark: assert property (p_idle_dark) else $error("display not dark after window");

endmodule
`default_nettype wire

// ### sim/blg_button_model.sv
// Pushbutton with pull-up on the display request pin, and a bar reader.
// Assumes the bench drives press from ref_clk edges; pin idles high.
`timescale 1ns/1ps
`default_nettype none
module blg_button_model (
	input  wire logic       press,
	input  wire logic [4:0] segment_out,
	output logic            pin,
	output logic [2:0]      lit_count
);
	// Switch to ground against a pull-up: released reads high
	assign pin = press ? 1'b0 : 1'b1;
	// Number of segments currently lit, for blink bookkeeping
	assign lit_count = 3'(segment_out[0]) + 3'(segment_out[1]) + 3'(segment_out[2])
		+ 3'(segment_out[3]) + 3'(segment_out[4]);
endmodule
`default_nettype wire

// ### sim/blg_gauge_display_tb_top.sv
// Self-checking bench for the LED charge gauge display.
// Assumes the block answers each bus access with one wait cycle.
`timescale 1ns/1ps
`default_nettype none
module blg_gauge_display_tb_top;
	import blg_pkg::*;
	localparam int DISPLAY_REQUEST_INPUT = 200;
	localparam int BLNK = 4;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        btn = 1'b0;
	logic        pin;
	logic        eod = 1'b0;
	logic [15:0] fcc = 16'd1000;
	logic [15:0] dc = 16'd2000;
	logic [15:0] rc = 16'd0;
	logic [4:0]  segment_out;
	logic [2:0]  lit_count;
	logic [31:0] rd;
	int          errors = 0;
	int          n_checks = 0;
	int          on_cnt;
	int          chg[22] = '{0, 199, 200, 339, 340, 399, 400, 499, 500, 599, 600, 669, 670,
		749, 750, 799, 800, 1000, 1339, 1340, 1999, 2000};

	always #25 ref_clk = ~ref_clk;

	blg_gauge_display #(.DISPLAY_REQUEST_INPUT_CYCLES(DISPLAY_REQUEST_INPUT), .BLINK_CYCLES(BLNK)) blg_gauge_display_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.display_request_input(pin), .end_of_discharge_flag(eod),
		.full_charge_capacity(fcc), .design_capacity(dc), .remaining_charge(rc),
		.segment_out(segment_out));

	blg_button_model blg_button_model_i (.press(btn), .segment_out(segment_out), .pin(pin),
		.lit_count(lit_count));

	// ****************************************
	// Checking and reporting
	// ****************************************
	task automatic fail(input string msg);
		errors++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) fail($sformatf("word %h, want %h", got, exp));
	endtask
	// Looks mid-cycle, then hands back on a rising edge so drives stay edge-aligned
	task automatic check_seg(input logic [4:0] exp);
		@(negedge ref_clk);
		n_checks++;
		if (segment_out !== exp) fail($sformatf("bar %b, want %b", segment_out, exp));
		@(posedge ref_clk);
	endtask
	task automatic final_report;
		$display("checks %0d, mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Expected bar from the boundary percentages of each segment count
	function automatic logic [4:0] exp_bar(input int c, input int rf, input int n);
		int b[4];
		int k;
		if (n == 5) begin
			b = '{20, 40, 60, 80};
		end else if (n == 4) begin
			b = '{25, 50, 75, 999};
		end else begin
			b = '{34, 67, 999, 999};
		end
		k = 1;
		for (int i = 0; i < 4; i++) if (c * 100 >= rf * b[i]) k++;
		return 5'((1 << k) - 1);
	endfunction

	// ****************************************
	// Bus and button drivers
	// ****************************************
	// Request held until an edge samples waitrequest low; data taken and released there
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) fail("bus access never answered");
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check_word(rd, exp);
	endtask
	task automatic press(input int hold);
		@(posedge ref_clk);
		btn <= 1'b1;
		repeat (hold) @(posedge ref_clk);
		btn <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// ****************************************
	// Watchdog
	// ****************************************
	initial begin
		settle(30000);
		fail("run timed out");
		final_report;
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		settle(4);
		rst_n <= 1'b1;
		settle(4);
		// Reset values, and a write then read at an unmapped offset
		rd_chk(REG_CTRL, 32'h4);
		rd_chk(REG_ALARM, 32'h0);
		bus(1'b1, 4'hc, 32'hffff_ffff);
		rd_chk(4'hc, 32'h0);
		check_seg(5'h00);
		$display("test registers done");
		// Every segment count in both scales, swept through the same 22 charge values
		for (int m = 0; m < 2; m++) begin
			// Count code 3 is the spare encoding and must behave as five
			for (int n = 3; n <= 6; n++) begin
				bus(1'b1, REG_CTRL, 32'(m) | (32'(n - 3) << 1));
				press(6);
				settle(2);
				foreach (chg[i]) begin
					rc <= 16'(chg[i]);
					settle(3);
					check_seg(exp_bar(chg[i], m ? 2000 : 1000, (n > 5) ? 5 : n));
				end
				settle(220);
				check_seg(5'h00);
			end
		end
		$display("test scales done");
		// A second fall mid-window, then held low past the window
		bus(1'b1, REG_CTRL, 32'h4);
		rc <= 16'd500;
		press(6);
		settle(4);
		check_seg(5'h07);
		settle(90);
		press(200);
		check_seg(5'h00);
		settle(80);
		check_seg(5'h00);
		$display("test retrigger done");
		// Below the alarm the lit bar blinks, half the time dark
		bus(1'b1, REG_ALARM, 32'd500);
		rc <= 16'd400;
		press(6);
		settle(6);
		// Read lands in the second lit half of the blink
		rd_chk(REG_STATUS, 32'h3 | (32'h07 << ST_SEG_LSB));
		on_cnt = 0;
		for (int i = 0; i < 4 * BLNK; i++) begin
			@(negedge ref_clk);
			if (lit_count == 3'd3) on_cnt++;
			else if (segment_out !== 5'h00) fail("blink shows a wrong bar");
		end
		check_word(32'(on_cnt), 32'(2 * BLNK));
		@(posedge ref_clk);
		rc <= 16'd600;
		settle(2 * BLNK);
		// Two looks half a blink period apart: a blinking bar would fail one
		check_seg(5'h0f);
		settle(BLNK - 1);
		check_seg(5'h0f);
		settle(220);
		$display("test blink done");
		// End of discharge refuses presses and blanks a live window
		eod <= 1'b1;
		press(6);
		settle(6);
		check_seg(5'h00);
		rd_chk(REG_STATUS, 32'h0 | (32'h1 << ST_EOD_BIT));
		eod <= 1'b0;
		settle(4);
		check_seg(5'h00);
		press(6);
		settle(4);
		check_seg(5'h0f);
		eod <= 1'b1;
		settle(1);
		check_seg(5'h00);
		eod <= 1'b0;
		settle(220);
		check_seg(5'h00);
		$display("test discharge done");
		final_report;
	end
endmodule
`default_nettype wire
